// ===== design/mcc_pkg.sv
package mcc_pkg;

	// Clock rate and timing
	localparam int unsigned CLK_MHZ      = 125;
	localparam int unsigned DLY_STEP_US  = 2000;
	localparam int unsigned DLY_STEP_CYC = DLY_STEP_US * CLK_MHZ;

	typedef int unsigned mcc_ct_tab_t [0:7];
	localparam mcc_ct_tab_t CT_US = '{50, 84, 150, 280, 540, 1052, 2074, 4120};

	function automatic mcc_ct_tab_t mcc_ct_cyc();
		mcc_ct_tab_t t;
		for (int i = 0; i < 8; i++) begin
			t[i] = CT_US[i] * CLK_MHZ;
		end
		return t;
	endfunction

	// Averaging counts as powers of two: 1,4,16,64,128,256,512,1024
	typedef logic [3:0] mcc_avg_sh_tab_t [0:7];
	localparam mcc_avg_sh_tab_t AVG_SHIFT = '{4'h0, 4'h2, 4'h4, 4'h6,
		4'h7, 4'h8, 4'h9, 4'ha};

	// Register pointers
	localparam logic [7:0] PTR_GEN_CFG = 8'h00;
	localparam logic [7:0] PTR_ADC_CFG = 8'h01;
	localparam logic [7:0] PTR_SHUNT   = 8'h04;
	localparam logic [7:0] PTR_BUS     = 8'h05;
	localparam logic [7:0] PTR_TEMP    = 8'h06;

	// Field positions and reset values
	localparam int unsigned GEN_RST_BIT   = 15;
	localparam int unsigned GEN_DLY_LSB   = 6;
	localparam int unsigned GEN_RANGE_BIT = 4;
	localparam logic [15:0] GEN_CFG_RST   = 16'h0000;
	localparam logic [15:0] ADC_CFG_RST   = 16'hfb68;
	localparam logic [15:0] TEMP_RES_MASK = 16'hfff0;
	localparam logic [1:0]  CH_NONE       = 2'h3;

	// Conversion configuration layout
	typedef struct packed {
		logic [3:0] mode;
		logic [2:0] bus_volt_conv_time;
		logic [2:0] shunt_volt_conv_time;
		logic [2:0] temperature_conv_time;
		logic [2:0] sample_averaging_count;
	} mcc_adc_cfg_t;

	// General configuration held fields
	typedef struct packed {
		logic [7:0] initial_conversion_delay;
		logic       shunt_range_select;
	} mcc_gen_cfg_t;

	// Measurement results
	typedef struct packed {
		logic [15:0] bus;
		logic [15:0] shunt_voltage_result;
		logic [15:0] temp;
	} mcc_results_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_DELAY = 2'b01,
		ST_CONV  = 2'b10
	} mcc_state_t;

endpackage

// ===== design/mcc_conv_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Reset bit restores all defaults, self-clears
// - Initial conversion delay in 2 ms steps
// - Reserved configuration bits always read zero
// - Range bit selects shunt full-scale range
// - Mode codes zero and eight mean shutdown
// - Codes one to seven trigger single shot
// - Codes nine to fifteen convert continuously
// - Bus conversion time from eight-step table
// - Shunt conversion time from same table
// - Temperature conversion time from same table
// - Averaging code picks 1 to 1024 samples
// - One averaging setting for all channels
// - Results update only after averaging completes
// - Shunt result two's complement, range-scaled weight
// - Pointer byte kept; registers sent MSB first
module mcc_conv_ctrl
	import mcc_pkg::*;
#(
	parameter int unsigned DLY_STEP_CYCLES = DLY_STEP_CYC,
	parameter mcc_ct_tab_t CT_CYCLES       = mcc_ct_cyc()
) (
	// Clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_in,
	// Register byte port, write side
	input  wire logic        wr_start_in,
	input  wire logic        wr_byte_valid_in,
	input  wire logic [7:0]  wr_byte_in,
	// Register byte port, read side
	input  wire logic        rd_start_in,
	input  wire logic        rd_byte_req_in,
	output logic      [7:0]  rd_byte_out,
	output logic             rd_byte_valid_out,
	// Converter side
	input  wire logic [15:0] adc_sample_in,
	output logic             adc_start_out,
	output logic      [1:0]  adc_channel_out,
	output logic             shunt_range_out,
	// Status and results
	output logic             engine_busy_out,
	output logic             conv_ready_out,
	output mcc_results_t     results_out
);

	mcc_gen_cfg_t        gen_cfg_r;
	mcc_adc_cfg_t        adc_cfg_r;
	mcc_state_t          state_r;
	logic                soft_rst_r;
	logic                rst_any;
	logic [7:0]          ptr_r;
	logic [7:0]          wr_msb_r;
	logic [1:0]          wr_idx_r;
	logic                wr_commit;
	logic [15:0]         wr_word;
	logic                adc_wr;
	logic                rd_idx_r;
	logic [7:0]          rd_lsb_r;
	logic [15:0]         rd_word;
	logic [19:0]         cnt_r;
	logic [7:0]          dly_left_r;
	logic [1:0]          ch_r;
	logic [10:0]         smp_r;
	logic signed [25:0]  acc_r;
	logic signed [25:0]  acc_nxt;
	logic [15:0]         avg_val;
	logic [2:0]          ch_mask;
	logic [2:0]          ct_code;
	logic [3:0]          avg_sh;
	logic [10:0]         smp_last;
	logic                conv_end;
	logic                last_smp;
	logic [1:0]          ch_next;
	logic [1:0]          ch_first;
	mcc_adc_cfg_t        adc_wr_word;
	logic                wr_gen;
	logic                mode_shut;
	logic                dly_done;
	logic                res_load;

	function automatic logic [1:0] next_ch(input logic [2:0] m,
		input logic [1:0] from);
		logic [1:0] r;
		r = CH_NONE;
		for (int i = 2; i >= 0; i--) begin
			if (m[i] && (2'(i) >= from)) begin
				r = 2'(i);
			end
		end
		return r;
	endfunction

	assign rst_any  = rst_in | soft_rst_r;
	assign wr_word  = {wr_msb_r, wr_byte_in};
	assign wr_commit = wr_byte_valid_in && (wr_idx_r == 2'h2);
	assign adc_wr   = wr_commit && (ptr_r == PTR_ADC_CFG);
	assign wr_gen   = wr_commit && (ptr_r == PTR_GEN_CFG);
	assign adc_wr_word = mcc_adc_cfg_t'(wr_word);
	assign mode_shut   = (adc_wr_word.mode[2:0] == 3'h0);
	assign ch_mask  = adc_cfg_r.mode[2:0];
	assign ch_first = next_ch(ch_mask, 2'h0);
	assign ch_next  = (ch_r == 2'h2) ? CH_NONE : next_ch(ch_mask, ch_r + 2'h1);

	// Conversion time per channel
	always_comb begin
		case (ch_r)
			2'h0: ct_code = adc_cfg_r.bus_volt_conv_time;
			2'h1: ct_code = adc_cfg_r.shunt_volt_conv_time;
			default: ct_code = adc_cfg_r.temperature_conv_time;
		endcase
	end

	// Averaging shared by all channels
	assign avg_sh   = AVG_SHIFT[adc_cfg_r.sample_averaging_count];
	assign smp_last = 11'((32'd1 << avg_sh) - 32'd1);
	assign conv_end = (cnt_r == 20'(CT_CYCLES[ct_code] - 1));
	assign last_smp = (smp_r == smp_last);
	assign acc_nxt  = acc_r + 26'(signed'(adc_sample_in));
	assign avg_val  = 16'(acc_nxt >>> avg_sh);
	assign dly_done = (dly_left_r == 8'h00);
	assign res_load = (state_r == ST_CONV) && conv_end && last_smp
		&& !adc_wr;

	// Register write byte sequencing
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			wr_idx_r <= 2'h0;
			ptr_r    <= PTR_GEN_CFG;
			wr_msb_r <= 8'h00;
		end else if (wr_start_in) begin
			wr_idx_r <= 2'h0;
		end else if (wr_byte_valid_in) begin
			case (wr_idx_r)
				2'h0: ptr_r <= wr_byte_in;
				2'h1: wr_msb_r <= wr_byte_in;
				default: ;
			endcase
			if (wr_idx_r != 2'h3) begin
				wr_idx_r <= wr_idx_r + 2'h1;
			end
		end
	end

	// Configuration registers
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			gen_cfg_r  <= mcc_gen_cfg_t'({GEN_CFG_RST[GEN_DLY_LSB +: 8],
				GEN_CFG_RST[GEN_RANGE_BIT]});
			adc_cfg_r  <= mcc_adc_cfg_t'(ADC_CFG_RST);
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_gen && wr_word[GEN_RST_BIT];
			if (wr_gen) begin
				gen_cfg_r.initial_conversion_delay <=
					wr_word[GEN_DLY_LSB +: 8];
				gen_cfg_r.shunt_range_select <=
					wr_word[GEN_RANGE_BIT];
			end
			if (adc_wr) begin
				adc_cfg_r <= mcc_adc_cfg_t'(wr_word);
			end
		end
	end

	// Read word selection
	always_comb begin
		case (ptr_r)
			PTR_GEN_CFG: begin
				rd_word = 16'h0000;
				rd_word[GEN_DLY_LSB +: 8] = gen_cfg_r.initial_conversion_delay;
				rd_word[GEN_RANGE_BIT] = gen_cfg_r.shunt_range_select;
			end
			PTR_ADC_CFG: rd_word = adc_cfg_r;
			PTR_SHUNT:   rd_word = results_out.shunt_voltage_result;
			PTR_BUS:     rd_word = results_out.bus;
			PTR_TEMP:    rd_word = results_out.temp & TEMP_RES_MASK;
			default:     rd_word = 16'h0000;
		endcase
	end

	// Register read, most significant byte first
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			rd_idx_r          <= 1'b0;
			rd_lsb_r          <= 8'h00;
			rd_byte_out       <= 8'h00;
			rd_byte_valid_out <= 1'b0;
		end else begin
			rd_byte_valid_out <= rd_byte_req_in;
			if (rd_start_in) begin
				rd_idx_r <= 1'b0;
			end else if (rd_byte_req_in) begin
				rd_idx_r <= ~rd_idx_r;
				if (!rd_idx_r) begin
					rd_byte_out <= rd_word[15:8];
					rd_lsb_r    <= rd_word[7:0];
				end else begin
					rd_byte_out <= rd_lsb_r;
				end
			end
		end
	end

	// Measurement sequencer
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			state_r       <= ST_DELAY;
			cnt_r         <= 20'h0_0000;
			dly_left_r    <= GEN_CFG_RST[GEN_DLY_LSB +: 8];
			ch_r          <= 2'h0;
			smp_r         <= 11'h000;
			acc_r         <= 26'h000_0000;
			adc_start_out <= 1'b0;
			conv_ready_out <= 1'b0;
		end else begin
			adc_start_out  <= 1'b0;
			conv_ready_out <= 1'b0;
			if (adc_wr) begin
				cnt_r      <= 20'h0_0000;
				dly_left_r <= gen_cfg_r.initial_conversion_delay;
				state_r    <= mode_shut ? ST_IDLE : ST_DELAY;
			end else begin
				case (state_r)
					ST_IDLE: ;
					ST_DELAY: begin
						if (dly_done) begin
							state_r       <= ST_CONV;
							ch_r          <= ch_first;
							cnt_r         <= 20'h0_0000;
							smp_r         <= 11'h000;
							acc_r         <= 26'h000_0000;
							adc_start_out <= 1'b1;
						end else if (cnt_r == 20'(DLY_STEP_CYCLES - 1)) begin
							cnt_r      <= 20'h0_0000;
							dly_left_r <= dly_left_r - 8'h01;
						end else begin
							cnt_r <= cnt_r + 20'h0_0001;
						end
					end
					ST_CONV: begin
						if (!conv_end) begin
							cnt_r <= cnt_r + 20'h0_0001;
						end else begin
							cnt_r         <= 20'h0_0000;
							adc_start_out <= 1'b1;
							if (!last_smp) begin
								smp_r <= smp_r + 11'h001;
								acc_r <= acc_nxt;
							end else begin
								smp_r <= 11'h000;
								acc_r <= 26'h000_0000;
								if (ch_next != CH_NONE) begin
									ch_r <= ch_next;
								end else if (adc_cfg_r.mode[3]) begin
									ch_r           <= ch_first;
									conv_ready_out <= 1'b1;
								end else begin
									state_r        <= ST_IDLE;
									adc_start_out  <= 1'b0;
									conv_ready_out <= 1'b1;
								end
							end
						end
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// Results written once per finished average
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			results_out <= '0;
		end else if (res_load) begin
			case (ch_r)
				2'h0: results_out.bus <= avg_val;
				2'h1: results_out.shunt_voltage_result <= avg_val;
				default: results_out.temp <= avg_val;
			endcase
		end
	end

	// Engine status outputs
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			engine_busy_out <= 1'b0;
			adc_channel_out <= 2'h0;
		end else begin
			engine_busy_out <= (state_r != ST_IDLE);
			adc_channel_out <= ch_r;
		end
	end

	// Shunt range output
	always_ff @(posedge ref_clk_in) begin
		if (rst_any) begin
			shunt_range_out <= GEN_CFG_RST[GEN_RANGE_BIT];
		end else begin
			shunt_range_out <= gen_cfg_r.shunt_range_select;
		end
	end

endmodule

// ===== testbench/mcc_adc_model.sv
`timescale 1ns/1ps
module mcc_adc_model (
	// Converter handshake
	input  wire logic        ref_clk_in,
	input  wire logic        start_in,
	input  wire logic [1:0]  channel_in,
	output logic      [15:0] sample_out
);
	logic tog_r = 1'b0;
	always @(posedge ref_clk_in) begin
		if (start_in) begin
			tog_r <= !tog_r;
		end
	end
	// Negative shunt value, alternating by two
	always_comb begin
		case (channel_in)
		2'h0: sample_out = 16'h1111;
		2'h1: sample_out = tog_r ? 16'hf224 : 16'hf222;
		2'h2: sample_out = 16'h3335;
		default: sample_out = {8{tog_r, !tog_r}};
		endcase
	end
endmodule

// ===== testbench/mcc_chk_assertions.sv
`timescale 1ns/1ps
module mcc_chk
	import mcc_pkg::*;
(
	input wire logic         ref_clk_in,
	input wire logic         rst_in,
	input wire logic         rd_byte_req_in,
	input wire logic         rd_byte_valid_out,
	input wire logic         adc_start_out,
	input wire logic         conv_ready_out,
	input wire logic         engine_busy_out,
	input wire mcc_results_t results_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	property p_rd; rd_byte_req_in |=> rd_byte_valid_out; endproperty
	a_rd: assert property (p_rd) else $error("read byte late");
	property p_rdc; rd_byte_valid_out |-> $past(rd_byte_req_in); endproperty
	a_rdc: assert property (p_rdc) else $error("stray read byte");
	property p_rst;
		disable iff (1'b0) rst_in |=> !adc_start_out && !conv_ready_out;
	endproperty
	a_rst: assert property (p_rst) else $error("active in reset");
	property p_boot; $fell(rst_in) |-> ##[0:2] adc_start_out; endproperty
	a_boot: assert property (p_boot) else $error("no start");
	property p_res;
		$changed(results_out) && results_out != '0 |-> engine_busy_out;
	endproperty
	a_res: assert property (p_res) else $error("result while idle");
	property p_rdy; conv_ready_out |=> !conv_ready_out; endproperty
	a_rdy: assert property (p_rdy) else $error("ready too long");
	property p_gap; adc_start_out |=> !adc_start_out [*2]; endproperty
	a_gap: assert property (p_gap) else $error("start too soon");
	property p_busy; adc_start_out |=> engine_busy_out; endproperty
	a_busy: assert property (p_busy) else $error("not busy");
endmodule
bind mcc_conv_ctrl mcc_chk u_mcc_chk (.ref_clk_in(ref_clk_in),
	.rst_in(rst_in), .rd_byte_req_in(rd_byte_req_in),
	.rd_byte_valid_out(rd_byte_valid_out), .adc_start_out(adc_start_out),
	.conv_ready_out(conv_ready_out), .engine_busy_out(engine_busy_out),
	.results_out(results_out));

// ===== testbench/monitor_conversion_config_tb_top.sv
`timescale 1ns/1ps
module monitor_conversion_config_tb_top;
	import mcc_pkg::*;
	localparam mcc_ct_tab_t CT = '{3, 4, 5, 6, 7, 8, 9, 10};
	logic         clk, rst, ws, wv, rs, rq, rv, st, rng, bsy, rdy;
	logic  [7:0]  wb, rb;
	logic  [15:0] smp;
	logic  [1:0]  ch;
	mcc_results_t res;
	int           n_fail = 0;
	int           n_checks = 0;
	int           n_st, n_rdy;
	mcc_conv_ctrl #(.DLY_STEP_CYCLES(4), .CT_CYCLES(CT)) u_mcc_conv_ctrl (
		.ref_clk_in(clk), .rst_in(rst), .wr_start_in(ws),
		.wr_byte_valid_in(wv), .wr_byte_in(wb), .rd_start_in(rs),
		.rd_byte_req_in(rq), .rd_byte_out(rb), .rd_byte_valid_out(rv),
		.adc_sample_in(smp), .adc_start_out(st), .adc_channel_out(ch),
		.shunt_range_out(rng), .engine_busy_out(bsy),
		.conv_ready_out(rdy), .results_out(res));
	mcc_adc_model u_mcc_adc_model (.ref_clk_in(clk), .start_in(st),
		.channel_in(ch), .sample_out(smp));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		n_st += int'(st === 1'b1);
		n_rdy += int'(rdy === 1'b1);
	end
	task automatic tally_and_finish();
		$display("checks %0d fails %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] p, logic [15:0] d, bit full = 1'b1);
		@(negedge clk);
		ws = 1'b1;
		@(negedge clk);
		ws = 1'b0;
		wv = 1'b1;
		wb = p;
		if (full) begin
			@(negedge clk);
			wb = d[15:8];
			@(negedge clk);
			wb = d[7:0];
		end
		@(negedge clk);
		wv = 1'b0;
	endtask
	task automatic rd(logic [7:0] p, output logic [15:0] w);
		wr(p, 16'h0000, 1'b0);
		rs = 1'b1;
		for (int i = 0; i < 2; i++) begin
			@(negedge clk);
			rs = 1'b0;
			rq = 1'b1;
			@(negedge clk);
			rq = 1'b0;
			w = {w[7:0], rb};
			chk("rd_valid", rv, 16'h0001);
		end
	endtask
	task automatic run(logic [15:0] cfg, int cyc);
		wr(8'h01, 16'h0000);
		repeat (2) @(negedge clk);
		n_st = 0;
		n_rdy = 0;
		wr(8'h01, cfg);
		repeat (cyc) @(negedge clk);
	endtask
	initial begin
		logic [15:0] w;
		int          g, pc;
		{ws, wv, wb, rs, rq} = '0;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		rd(8'h00, w);
		chk("gen_cfg", w, GEN_CFG_RST);
		rd(8'h01, w);
		chk("adc_cfg", w, ADC_CFG_RST);
		wr(8'h00, 16'h7fff);
		rd(8'h00, w);
		chk("gen_rsvd", w, 16'h3fd0);
		chk("range1", rng, 16'h0001);
		wr(8'h00, 16'h0000);
		@(negedge clk);
		chk("range0", rng, 16'h0000);
		$display("test config_fields done");
		for (int d = 0; d <= 2; d += 2) begin
			wr(8'h00, 16'(d << 6));
			run(16'h9000, 0);
			for (g = 1; st !== 1'b1 && g < 50; g++) @(negedge clk);
			chk("init_dly", g >= 4 * d - 1 && g <= 4 * d + 2, 1);
		end
		wr(8'h01, 16'h1234);
		wr(8'h00, 16'h8000);
		rd(8'h00, w);
		chk("soft_gen", w, GEN_CFG_RST);
		rd(8'h01, w);
		chk("soft_adc", w, ADC_CFG_RST);
		$display("test delay_softreset done");
		for (int m = 0; m < 16; m++) begin
			run({4'(m), 12'h000}, 60);
			pc = m % 2 + (m / 2) % 2 + (m / 4) % 2;
			if (pc == 0) chk("idle", n_st, 0);
			else if (m < 8) chk("shot", n_st, pc);
			else chk("cont", n_st > 3 * pc, 1);
			if (m < 8 && pc > 0) chk("done", n_rdy, 1);
			chk("busy", bsy, 16'(m > 8));
		end
		$display("test modes done");
		run(16'h3001, 80);
		chk("avg_starts", n_st, 8);
		chk("avg_ready", n_rdy, 1);
		rd(8'h05, w);
		chk("bus_res", w, 16'h1111);
		rd(8'h04, w);
		chk("shunt_res", w, 16'hf223);
		run(16'h3007, 200);
		chk("avg_long", n_rdy, 0);
		chk("avg_hold", res.bus, 16'h1111);
		$display("test averaging done");
		for (int c = 0; c < 3; c++) begin
			for (int k = 0; k < 8; k++) begin
				run({4'h8 | 4'(1 << c), 12'h000} | 16'(k << (9 - 3 * c)), 0);
				for (g = 0; st !== 1'b1 && g < 50; g++) @(negedge clk);
				@(negedge clk);
				for (g = 1; st !== 1'b1 && g < 50; g++) @(negedge clk);
				chk("conv_time", g, CT[k]);
				chk("channel", ch, 16'(c));
			end
		end
		$display("test conv_times done");
		tally_and_finish();
	end
	initial begin
		#200_000;
		n_fail++;
		tally_and_finish();
	end
endmodule
